//--- hdl/rai_pkg.sv
/*
 * rai_pkg: shared constants for the two-wire register access port.
 * assumes a single 125 mhz system clock on both ends of the link.
 */
package rai_pkg;
    // system clock rate in khz, period 8 ns
    localparam int CLK_KHZ = 125000;
    // fastest bus rate the port must follow, in khz
    localparam int FAST_KHZ = 400;
    // cycles per quarter of a host bit slot, rounded up so rate stays legal
    localparam int QTR_CYC = (CLK_KHZ + 4 * FAST_KHZ - 1) / (4 * FAST_KHZ);
    // fixed 7-bit slave address
    localparam logic [6:0] SLAVE_ADDR = 7'h32;
    // address bytes with the direction bit, write 0 and read 1
    localparam logic [7:0] ADDR_WR = 8'h64;
    localparam logic [7:0] ADDR_RD = 8'h65;
    // bus timeout in seconds and the time base ticks per second
    localparam int TIMEOUT_S = 1;
    localparam int TICK_HZ = 1024;
    localparam int TIMEOUT_TICKS = TIMEOUT_S * TICK_HZ;
    // bit index of the acknowledge slot within a byte
    localparam logic [3:0] ACK_SLOT = 4'h8;
    // value seen when nobody pulls the data line
    localparam logic [7:0] IDLE_BYTE = 8'hff;
endpackage

//--- hdl/rai_link_if.sv
/*
 * rai_link_if: the two-wire link between host and device.
 * both lines are open drain with a pull-up; a low output enable
 * means that party pulls its line low.
 */
`timescale 1ns/10ps
`default_nettype none
interface rai_link_if;
    logic scl;        // resolved clock line
    logic sda;        // resolved data line
    logic h_scl_o;    // host clock drive value
    logic h_scl_oe_n; // host pulls clock low when low
    logic h_sda_o;    // host data drive value
    logic h_sda_oe_n; // host pulls data low when low
    logic d_sda_o;    // device data drive value
    logic d_sda_oe_n; // device pulls data low when low

    // wired-and with pull-up: released lines read high
    assign scl = h_scl_oe_n | h_scl_o;
    assign sda = (h_sda_oe_n | h_sda_o) & (d_sda_oe_n | d_sda_o);

    modport host (input sda, output h_scl_o, output h_scl_oe_n,
                  output h_sda_o, output h_sda_oe_n);
    modport device (input scl, input sda, output d_sda_o,
                    output d_sda_oe_n);
endinterface
`default_nettype wire

//--- hdl/rai_host.sv
/*
 * rai_host: bus master end that drives register transfers.
 * assumes the link interface resolves the open-drain lines and that
 * the user holds command fields steady while busy is high.
 */
`timescale 1ns/10ps
`default_nettype none
module rai_host
    import rai_pkg::*;
#(
    parameter int QTR = QTR_CYC
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    rai_link_if.host link,
    input wire logic cmd_go,
    input wire logic cmd_read,
    input wire logic cmd_skip_addr,
    input wire logic [7:0] cmd_reg,
    input wire logic [7:0] cmd_wdata,
    input wire logic [3:0] cmd_count,
    output logic busy,
    output logic done,
    output logic nack_err,
    output logic rd_valid,
    output logic [7:0] rd_byte
);
    typedef enum {H_IDLE, H_START, H_BYTE, H_STOP} rai_hst_t;
    typedef enum {Q_AW, Q_REG, Q_WD, Q_AR, Q_RD} rai_seq_t;

    rai_hst_t st_reg;       // slot kind in progress
    rai_seq_t seq_reg;      // which byte of the transfer
    logic [15:0] div_reg;   // quarter divider
    logic [1:0] q_reg;      // quarter within slot
    logic [3:0] bit_reg;    // bit within byte slot
    logic [8:0] tx_reg;     // bits to send, msb first
    logic [8:0] rx_reg;     // sampled bits
    logic [3:0] left_reg;   // read bytes still to fetch
    logic sr_reg;           // next start is a repeated start
    logic sda_m, sda_s;     // data line synchroniser
    logic scl_want, sda_want;
    logic qtick;

    assign qtick = (div_reg == 16'(QTR - 1));

    // data pin passes two flops before use
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sda_m <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            sda_m <= link.sda;
            sda_s <= sda_m;
        end
    end

    // line levels for the current quarter
    always_comb begin
        scl_want = 1'b1;
        sda_want = 1'b1;
        case (st_reg)
            H_START: begin
                scl_want = (q_reg == 2'd1) || (q_reg == 2'd2);
                sda_want = (q_reg < 2'd2);
            end
            H_STOP: begin
                scl_want = (q_reg != 2'd0);
                sda_want = (q_reg >= 2'd2);
            end
            H_BYTE: begin
                scl_want = (q_reg == 2'd1) || (q_reg == 2'd2);
                sda_want = tx_reg[8];
            end
            default: begin
                scl_want = 1'b1;
                sda_want = 1'b1;
            end
        endcase
    end

    // open drain: only pull low, otherwise release
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            link.h_scl_oe_n <= 1'b1;
            link.h_sda_oe_n <= 1'b1;
            link.h_scl_o <= 1'b0;
            link.h_sda_o <= 1'b0;
        end else begin
            link.h_scl_oe_n <= scl_want;
            link.h_sda_oe_n <= sda_want;
            link.h_scl_o <= 1'b0;
            link.h_sda_o <= 1'b0;
        end
    end

    // slot sequencer, one step per quarter tick
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_reg <= H_IDLE;
            seq_reg <= Q_AW;
            div_reg <= 16'h0000;
            q_reg <= 2'd0;
            bit_reg <= 4'h0;
            tx_reg <= 9'h1ff;
            rx_reg <= 9'h1ff;
            left_reg <= 4'h0;
            sr_reg <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            nack_err <= 1'b0;
            rd_valid <= 1'b0;
            rd_byte <= 8'h00;
        end else begin
            done <= 1'b0;
            rd_valid <= 1'b0;
            div_reg <= qtick ? 16'h0000 : div_reg + 16'h0001;
            if (st_reg == H_IDLE) begin
                div_reg <= 16'h0000;
                q_reg <= 2'd0;
                sr_reg <= 1'b0;
                if (cmd_go) begin
                    // every transfer opens with a fresh start
                    st_reg <= H_START;
                    busy <= 1'b1;
                    nack_err <= 1'b0;
                    left_reg <= cmd_count;
                end
            end else if (qtick) begin
                q_reg <= q_reg + 2'd1;
                // sample late in the high phase
                if (st_reg == H_BYTE && q_reg == 2'd2) begin
                    rx_reg <= {rx_reg[7:0], sda_s};
                end
                if (q_reg == 2'd3) begin
                    case (st_reg)
                        H_START: begin
                            st_reg <= H_BYTE;
                            bit_reg <= 4'h0;
                            if (sr_reg || (cmd_read && cmd_skip_addr)) begin
                                seq_reg <= Q_AR;
                                tx_reg <= {ADDR_RD, 1'b1};
                            end else begin
                                seq_reg <= Q_AW;
                                tx_reg <= {ADDR_WR, 1'b1};
                            end
                        end
                        H_BYTE: begin
                            bit_reg <= bit_reg + 4'h1;
                            tx_reg <= {tx_reg[7:0], 1'b1};
                            if (bit_reg == ACK_SLOT) begin
                                bit_reg <= 4'h0;
                                if (seq_reg == Q_RD) begin
                                    rd_valid <= 1'b1;
                                    rd_byte <= rx_reg[8:1];
                                    left_reg <= left_reg - 4'h1;
                                    if (left_reg <= 4'h1) begin
                                        st_reg <= H_STOP;
                                    end else begin
                                        tx_reg <= {IDLE_BYTE,
                                                   left_reg == 4'h2};
                                    end
                                end else if (rx_reg[0]) begin
                                    // refused byte, abandon with stop
                                    nack_err <= 1'b1;
                                    st_reg <= H_STOP;
                                end else begin
                                    case (seq_reg)
                                        Q_AW: begin
                                            seq_reg <= Q_REG;
                                            tx_reg <= {cmd_reg, 1'b1};
                                        end
                                        Q_REG: begin
                                            if (cmd_read) begin
                                                st_reg <= H_START;
                                                sr_reg <= 1'b1;
                                            end else begin
                                                seq_reg <= Q_WD;
                                                tx_reg <= {cmd_wdata, 1'b1};
                                            end
                                        end
                                        Q_AR: begin
                                            seq_reg <= Q_RD;
                                            tx_reg <= {IDLE_BYTE,
                                                       left_reg <= 4'h1};
                                        end
                                        default: st_reg <= H_STOP;
                                    endcase
                                end
                            end
                        end
                        H_STOP: begin
                            st_reg <= H_IDLE;
                            busy <= 1'b0;
                            done <= 1'b1;
                        end
                        default: st_reg <= H_IDLE;
                    endcase
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- hdl/rai_device.sv
/*
 * rai_device: slave end of the two-wire register access port.
 * assumes the register file sits on ref_clk and answers rd_data
 * combinationally from reg_addr; tick is a 1024 hz one-cycle enable
 * from the timekeeping divider on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module rai_device
    import rai_pkg::*;
#(
    parameter int TO_TICKS = TIMEOUT_TICKS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    rai_link_if.device link,
    input wire logic tick,
    input wire logic [7:0] rd_data,
    output logic [7:0] reg_addr,
    output logic [7:0] register_write_byte,
    output logic wr_stb,
    output logic rd_stb,
    output logic bus_timeout
);
    typedef enum {D_IDLE, D_ADDR, D_ADDR_ACK, D_REG, D_REG_ACK, D_WR,
                  D_WR_ACK, D_RD, D_RD_ACK, D_SKIP} rai_dst_t;

    rai_dst_t st_reg;        // byte level state
    logic scl_m, scl_s, scl_d; // clock synchroniser and history
    logic sda_m, sda_s, sda_d; // data synchroniser and history
    logic [7:0] sh_reg;      // incoming byte
    logic [7:0] tx_reg;      // outgoing byte, msb on the line
    logic [3:0] cnt_reg;     // bits seen in current byte
    logic rw_reg;            // direction of the current transfer
    logic armed_reg;         // timer runs after an address byte
    logic [15:0] to_reg;     // time base ticks while armed
    logic to_pulse;          // port reset request from the timer
    logic scl_rise, scl_fall, start_c, stop_c;

    // edges and bus conditions from the synchronised lines
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    // start: data falls while clock stays high; stop: data rises
    assign start_c = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_c = scl_s & scl_d & ~sda_d & sda_s;

    // oversampling keeps up with fast mode
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= link.scl;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= link.sda;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    // bus timeout counter on the timekeeping tick
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            armed_reg <= 1'b0;
            to_reg <= 16'h0000;
            to_pulse <= 1'b0;
            bus_timeout <= 1'b0;
        end else begin
            to_pulse <= 1'b0;
            bus_timeout <= 1'b0;
            if (start_c || stop_c) begin
                // any start or stop clears it
                armed_reg <= 1'b0;
                to_reg <= 16'h0000;
            end else if (st_reg == D_ADDR && scl_fall
                         && cnt_reg == ACK_SLOT) begin
                armed_reg <= 1'b1;
                to_reg <= 16'h0000;
            end else if (armed_reg && tick) begin
                to_reg <= to_reg + 16'h0001;
                if (to_reg == 16'(TO_TICKS - 1)) begin
                    armed_reg <= 1'b0;
                    to_pulse <= 1'b1;
                    bus_timeout <= 1'b1;
                end
            end
        end
    end

    // byte engine: shifts on clock edges, acts on conditions
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_reg <= D_IDLE;
            sh_reg <= 8'h00;
            tx_reg <= IDLE_BYTE;
            cnt_reg <= 4'h0;
            rw_reg <= 1'b0;
            reg_addr <= 8'h00;
            register_write_byte <= 8'h00;
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            // data starts released, never driven high
            link.d_sda_oe_n <= 1'b1;
            link.d_sda_o <= 1'b0;
        end else begin
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            link.d_sda_o <= 1'b0;
            if (start_c) begin
                // a start or repeated start always listens afresh
                st_reg <= D_ADDR;
                cnt_reg <= 4'h0;
                link.d_sda_oe_n <= 1'b1;
            end else if (stop_c || to_pulse) begin
                // release and wait for a new start
                // released line reads as all ones
                st_reg <= D_IDLE;
                link.d_sda_oe_n <= 1'b1;
            end else begin
                case (st_reg)
                    D_ADDR, D_REG, D_WR: begin
                        if (scl_rise) begin
                            sh_reg <= {sh_reg[6:0], sda_s};
                            cnt_reg <= cnt_reg + 4'h1;
                        end else if (scl_fall && cnt_reg == ACK_SLOT) begin
                            cnt_reg <= 4'h0;
                            link.d_sda_oe_n <= 1'b0;
                            if (st_reg == D_ADDR) begin
                                if (sh_reg[7:1] == SLAVE_ADDR) begin
                                    rw_reg <= sh_reg[0];
                                    st_reg <= D_ADDR_ACK;
                                end else begin
                                    link.d_sda_oe_n <= 1'b1;
                                    st_reg <= D_SKIP;
                                end
                            end else if (st_reg == D_REG) begin
                                reg_addr <= sh_reg;
                                st_reg <= D_REG_ACK;
                            end else begin
                                register_write_byte <= sh_reg;
                                wr_stb <= 1'b1;
                                st_reg <= D_WR_ACK;
                            end
                        end
                    end
                    D_ADDR_ACK: begin
                        if (scl_fall) begin
                            if (rw_reg) begin
                                tx_reg <= rd_data;
                                rd_stb <= 1'b1;
                                link.d_sda_oe_n <= rd_data[7];
                                st_reg <= D_RD;
                            end else begin
                                link.d_sda_oe_n <= 1'b1;
                                st_reg <= D_REG;
                            end
                        end
                    end
                    D_REG_ACK: begin
                        if (scl_fall) begin
                            link.d_sda_oe_n <= 1'b1;
                            st_reg <= D_WR;
                        end
                    end
                    D_WR_ACK: begin
                        if (scl_fall) begin
                            reg_addr <= {reg_addr[7:4], reg_addr[3:0] + 4'h1};
                            link.d_sda_oe_n <= 1'b1;
                            st_reg <= D_WR;
                        end
                    end
                    D_RD: begin
                        if (scl_rise) begin
                            cnt_reg <= cnt_reg + 4'h1;
                        end else if (scl_fall) begin
                            if (cnt_reg == ACK_SLOT) begin
                                // low nibble steps after a read
                                reg_addr <= {reg_addr[7:4],
                                             reg_addr[3:0] + 4'h1};
                                link.d_sda_oe_n <= 1'b1;
                                st_reg <= D_RD_ACK;
                            end else begin
                                tx_reg <= {tx_reg[6:0], 1'b1};
                                link.d_sda_oe_n <= tx_reg[6];
                            end
                        end
                    end
                    D_RD_ACK: begin
                        if (scl_rise && sda_s) begin
                            st_reg <= D_SKIP;
                        end else if (scl_fall) begin
                            // ack asks for the next byte
                            tx_reg <= rd_data;
                            rd_stb <= 1'b1;
                            cnt_reg <= 4'h0;
                            link.d_sda_oe_n <= rd_data[7];
                            st_reg <= D_RD;
                        end
                    end
                    D_SKIP: begin
                        // line stays released until the next condition
                        link.d_sda_oe_n <= 1'b1;
                    end
                    default: begin
                        link.d_sda_oe_n <= 1'b1;
                        st_reg <= D_IDLE;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- bench/rai_checker.sv
/*
 * rai_checker: wire-level checks on the two-wire link.
 * assumes one ref_clk domain and the host at a quarter of 4 cycles.
 */
`timescale 1ns/10ps
`default_nettype none
module rai_checker
    import rai_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic d_sda_o,
    input wire logic d_sda_oe_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic scl_q, sda_q; // lines one cycle back
    logic first, wr_d, rd_d; // address byte pending, direction seen
    logic [3:0] cnt; // bit slot within the byte
    logic [7:0] sh; // bits taken on scl rise
    wire rise = scl & ~scl_q;
    wire start_c = scl & scl_q & sda_q & ~sda;
    wire stop_c = scl & scl_q & ~sda_q & sda;
    wire match = sh[7:1] == SLAVE_ADDR;
    // byte tracker; restarts on start and stop like the device does
    always_ff @(posedge ref_clk) begin
        scl_q <= scl;
        sda_q <= sda;
        if (sys_rst || start_c || stop_c) begin
            cnt <= 4'h0;
            first <= 1'b1;
            wr_d <= 1'b0;
            rd_d <= 1'b0;
        end else if (rise) begin
            cnt <= (cnt == ACK_SLOT) ? 4'h0 : cnt + 4'h1;
            if (cnt < ACK_SLOT) sh <= {sh[6:0], sda};
            if (cnt == ACK_SLOT) first <= 1'b0;
            if (cnt == ACK_SLOT && first) wr_d <= match && !sh[0];
            if (cnt == ACK_SLOT && first) rd_d <= match && sh[0];
        end
    end
    property p_rel_reset;
        $fell(sys_rst) |-> scl && sda && d_sda_oe_n;
    endproperty
    a_rel_reset: assert property (p_rel_reset)
        else $error("lines not released after reset");
    property p_drive_low;
        d_sda_o == 1'b0;
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("device drives data high");
    property p_addr_quiet;
        rise && first && cnt < ACK_SLOT |-> d_sda_oe_n;
    endproperty
    a_addr_quiet: assert property (p_addr_quiet)
        else $error("device drove during address bits");
    property p_addr_ack;
        rise && first && cnt == ACK_SLOT |-> sda != match;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("address acknowledge wrong");
    property p_wr_ack;
        rise && wr_d && cnt == ACK_SLOT |-> !sda;
    endproperty
    a_wr_ack: assert property (p_wr_ack)
        else $error("written byte not acknowledged");
    property p_wr_free;
        rise && wr_d && cnt < ACK_SLOT |-> d_sda_oe_n;
    endproperty
    a_wr_free: assert property (p_wr_free)
        else $error("device held line during write bits");
    property p_rd_free;
        rise && rd_d && cnt == ACK_SLOT |-> d_sda_oe_n;
    endproperty
    a_rd_free: assert property (p_rd_free)
        else $error("device drove host acknowledge slot");
    property p_oe_scl_low;
        $fell(d_sda_oe_n) |-> !scl;
    endproperty
    a_oe_scl_low: assert property (p_oe_scl_low)
        else $error("device pulled data with clock high");
    property p_scl_high;
        rise |-> scl [*4];
    endproperty
    a_scl_high: assert property (p_scl_high)
        else $error("clock high time too short");
    c_wr: cover property (rise && wr_d && cnt == ACK_SLOT);
    c_rd: cover property (rise && rd_d && cnt == ACK_SLOT);
    c_stop: cover property (stop_c);
endmodule
`default_nettype wire

//--- bench/rtc_i2c_register_access_bench.sv
/*
 * bench: host end and device end joined by the link interface.
 * assumes quarter of 4 cycles and a timeout of four ticks.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
    n_tests++; \
    if ((got) !== (ex)) begin \
        $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
        num_errors++; \
    end
module rtc_i2c_register_access_bench
    import rai_pkg::*;
;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic tick = 1'b0, go = 1'b0, rd = 1'b0, skip = 1'b0;
    logic [7:0] reg_a = 8'h00, wdat = 8'h00, ptr = 8'h00;
    logic [3:0] cnt = 4'h1;
    logic done, nack_err, rd_valid, wr_stb, bus_timeout, busy, rd_stb;
    logic [7:0] rd_byte, reg_addr, register_write_byte, rd_data;
    logic [7:0] mem [256]; // register file behind the device
    logic [7:0] exp [256]; // expected contents
    logic [7:0] got [$]; // bytes the host handed back
    int num_errors = 0, n_tests = 0, cyc = 0, tick_per = 1000, n_to = 0;
    int n_rs = 0; // register loads the device made for sending
    rai_link_if u_rai_link_if ();
    rai_host #(.QTR(4)) u_rai_host (.ref_clk, .sys_rst,
        .link(u_rai_link_if), .cmd_go(go), .cmd_read(rd),
        .cmd_skip_addr(skip), .cmd_reg(reg_a), .cmd_wdata(wdat),
        .cmd_count(cnt), .busy, .done, .nack_err, .rd_valid, .rd_byte);
    rai_device #(.TO_TICKS(4)) u_rai_device (.ref_clk, .sys_rst,
        .link(u_rai_link_if), .tick, .rd_data, .reg_addr,
        .register_write_byte, .wr_stb, .rd_stb, .bus_timeout);
    rai_checker u_rai_checker (.ref_clk, .sys_rst,
        .scl(u_rai_link_if.scl), .sda(u_rai_link_if.sda),
        .d_sda_o(u_rai_link_if.d_sda_o),
        .d_sda_oe_n(u_rai_link_if.d_sda_oe_n));
    assign rd_data = mem[reg_addr];
    initial forever #4 ref_clk = ~ref_clk;
    // time base, register file, capture and watchdog
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        tick <= (cyc % tick_per) == 0;
        if (wr_stb) mem[reg_addr] <= register_write_byte;
        if (rd_valid) got.push_back(rd_byte);
        if (bus_timeout) n_to <= n_to + 1;
        if (rd_stb) n_rs <= n_rs + 1;
        if (cyc == 60000) begin
            num_errors++;
            close_out();
        end
    end
    // one host command, waited on with a bound
    task automatic xfer(input logic r, s, input logic [7:0] a, d,
                        input logic [3:0] n);
        int w;
        @(posedge ref_clk);
        go <= 1'b1;
        rd <= r;
        skip <= s;
        reg_a <= a;
        wdat <= d;
        cnt <= n;
        @(posedge ref_clk);
        go <= 1'b0;
        w = 0;
        @(negedge ref_clk);
        `CHK("busy", 1'b1, busy)
        while (done !== 1'b1 && w < 20000) begin
            @(negedge ref_clk);
            w++;
        end
        `CHK("done", 1'b1, done)
        `CHK("idle", 1'b0, busy)
        `CHK("nack", 1'b0, nack_err)
    endtask
    // write one byte; pointer moves on in the low nibble only
    task automatic wr(input logic [7:0] a, d);
        xfer(1'b0, 1'b0, a, d, 4'h1);
        exp[a] = d;
        ptr = {a[7:4], a[3:0] + 4'h1};
        `CHK("ptr", ptr, reg_addr)
    endtask
    // read n bytes from a, or from the retained pointer when s is set
    task automatic rdn(input logic s, input logic [7:0] a,
                       input logic [3:0] n);
        int s0;
        got = {};
        s0 = n_rs;
        if (!s) ptr = a;
        xfer(1'b1, s, a, 8'h00, n);
        `CHK("count", 32'(n), got.size())
        `CHK("loads", 32'(n), n_rs - s0)
        foreach (got[i]) begin
            `CHK("byte", exp[ptr], got[i])
            ptr[3:0] = ptr[3:0] + 4'h1;
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        foreach (mem[i]) begin
            mem[i] = 8'(i) ^ 8'h5a;
            exp[i] = mem[i];
        end
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (4) @(negedge ref_clk);
        `CHK("sda", 1'b1, u_rai_link_if.sda)
        wr(8'h2f, 8'ha5);
        wr(8'h13, 8'h3c);
        $display("test write done");
        rdn(1'b0, 8'h13, 4'h1);
        rdn(1'b0, 8'h2e, 4'h4);
        rdn(1'b1, 8'h00, 4'h2);
        $display("test read done");
        tick_per = 100;
        got = {};
        xfer(1'b1, 1'b1, 8'h00, 8'h00, 4'h8);
        `CHK("first", exp[8'h24], got[0])
        `CHK("late", IDLE_BYTE, got[7])
        `CHK("timeout", 1, n_to)
        tick_per = 1000;
        rdn(1'b0, 8'h2f, 4'h2);
        $display("test timeout done");
        close_out();
    end
endmodule
`default_nettype wire
